// ---- hsfw_defs.svh ----
// Constants for the host serial, flow and wake block
`ifndef HSFW_DEFS_SVH
`define HSFW_DEFS_SVH
`define HSFW_CLK_HZ        10000000
`define HSFW_BAUD_DEF      9600
`define HSFW_DATA_BITS     8
`define HSFW_PWM_BITS      16
`define HSFW_ADC_BITS      10
`define HSFW_GPIO_N        4
`define HSFW_RX_DEPTH      2
`define HSFW_SPI_DIV       4
`define HSFW_SPI_LAST_EDGE 4'hF
`define HSFW_LAST_BIT      3'h7
`endif

// ---- hsfw_pkg.sv ----
// Types for the host serial, flow and wake block
package hsfw_pkg;
   typedef enum logic [3:0] {
      HSFW_TX_IDLE  = 4'b0001,
      HSFW_TX_START = 4'b0010,
      HSFW_TX_DATA  = 4'b0100,
      HSFW_TX_STOP  = 4'b1000
   } hsfw_tx_e;
   typedef enum logic [3:0] {
      HSFW_RX_IDLE  = 4'b0001,
      HSFW_RX_START = 4'b0010,
      HSFW_RX_DATA  = 4'b0100,
      HSFW_RX_STOP  = 4'b1000
   } hsfw_rx_e;
   typedef enum logic [1:0] {
      HSFW_AWAKE = 2'b01,
      HSFW_SLEEP = 2'b10
   } hsfw_pwr_e;
   // Byte stream with handshake
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } hsfw_byte_s;
   // Two-signal pin
   typedef struct packed {
      logic o;
      logic oe_n;
   } hsfw_pin_s;
endpackage

// ---- hsfw_pwm.sv ----
// Sixteen-bit duty output with first-order digital smoothing
`timescale 1ns/100ps
`include "hsfw_defs.svh"
module hsfw_pwm #(
   parameter int W = `HSFW_PWM_BITS
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   // Duty setting and output
   input  wire logic [W-1:0] duty,
   output logic              pwm_out,
   output logic [W-1:0]      filt_out
);
   import hsfw_pkg::*;
   if (W < 2 || W > 24) begin : g_bad_width
      $error("hsfw_pwm: width out of range");
   end
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         pwm;
      logic [W+3:0] acc;
   } hsfw_pwm_s;
   hsfw_pwm_s s_q, s_d;
   always_comb begin
      s_d     = s_q;
      s_d.cnt = s_q.cnt + 1'b1;
      s_d.pwm = (s_q.cnt < duty);
      // First-order low-pass: acc += (in - acc/16)
      s_d.acc = s_q.acc - (s_q.acc >> 4)
              + {4'h0, (s_q.pwm ? {W{1'b1}} : {W{1'b0}})};
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign pwm_out  = s_q.pwm;
   assign filt_out = s_q.acc[W+3:4];
   AST_PWM_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
      (duty == '0) |=> !pwm_out) else $error("pwm high at zero duty");
endmodule

// ---- hsfw_top.sv ----
// Host-side serial, flow control, SPI pins, wake, GPIO, PWM and ADC
// Notes on behaviour
// - ready-to-receive output low whenever a serial input byte fits.
// - module starts no new serial byte while host-ready is high.
// - low hardware reset holds whole module in reset.
// - high wake input brings module out of timer sleep.
// - wake indication output goes high on waking from timer sleep.
// - SPI select driven as master, released (not driven) as slave.
// - SPI clock driven as master, released (not driven) as slave.
// - master samples SPI input pin, shifts out on SPI output pin.
// - each general pin enables weak pull-up when configured input.
// - one 16-bit duty output followed by first-order low-pass filter.
`timescale 1ns/100ps
`include "hsfw_defs.svh"
module hsfw_top #(
   parameter int CLK_HZ = `HSFW_CLK_HZ,
   parameter int BAUD   = `HSFW_BAUD_DEF,
   parameter int SPI_DV = `HSFW_SPI_DIV
) (
   // Clock and resets
   input  wire logic                          core_clk,
   input  wire logic                          sys_rst,
   input  wire logic                          hw_reset_n,
   // Data serial port and flow control
   input  wire logic                          serial_in,
   output logic                               serial_out,
   output logic                               host_ready_to_rx_n,
   input  wire logic                          host_ready_n,
   // Core byte streams
   input  wire hsfw_pkg::hsfw_byte_s          tx_byte,
   output logic                               tx_ready,
   output hsfw_pkg::hsfw_byte_s               rx_byte,
   input  wire logic                          rx_ready,
   // SPI pins and control
   input  wire logic                          spi_master,
   input  wire logic                          spi_start,
   input  wire logic [7:0]                    spi_tx_data,
   output logic [7:0]                         spi_rx_data,
   output logic                               spi_busy,
   input  wire logic                          spi_in,
   output logic                               spi_out,
   input  wire logic                          spi_sel_n_i,
   output hsfw_pkg::hsfw_pin_s                spi_sel_n,
   input  wire logic                          spi_clk_i,
   output hsfw_pkg::hsfw_pin_s                spi_clk,
   // Wake and sleep
   input  wire logic                          sleep_req,
   input  wire logic                          wake_in,
   output logic                               wake_out,
   output logic                               asleep,
   // General pins
   input  wire logic [`HSFW_GPIO_N-1:0]       gp_dir_out,
   input  wire logic [`HSFW_GPIO_N-1:0]       gp_wr,
   input  wire logic [`HSFW_GPIO_N-1:0]       gp_i,
   output logic [`HSFW_GPIO_N-1:0]            gp_o,
   output logic [`HSFW_GPIO_N-1:0]            gp_oe_n,
   output logic [`HSFW_GPIO_N-1:0]            gp_pullup,
   output logic [`HSFW_GPIO_N-1:0]            gp_rd,
   // Duty output
   input  wire logic [`HSFW_PWM_BITS-1:0]     duty_set,
   output logic                               duty_output_0,
   output logic [`HSFW_PWM_BITS-1:0]          duty_filtered,
   // Analog inputs, sampled from converter front end
   input  wire logic [`HSFW_ADC_BITS-1:0]     analog_in_0,
   input  wire logic [`HSFW_ADC_BITS-1:0]     analog_in_1,
   input  wire logic                          adc_ref_sel,
   output logic [`HSFW_ADC_BITS-1:0]          adc_code_0,
   output logic [`HSFW_ADC_BITS-1:0]          adc_code_1
);
   import hsfw_pkg::*;
   localparam int BIT_CYC = CLK_HZ / BAUD;
   localparam int HALF    = BIT_CYC / 2;
   // Bit counter is 16 bits wide; below 4 cycles mid-bit sampling fails
   if (BIT_CYC < 4 || BIT_CYC > 65535) begin : g_bad_baud
      $error("hsfw_top: bad baud");
   end
   if (SPI_DV < 2 || SPI_DV > 255) begin : g_bad_div
      $error("hsfw_top: bad SPI divider");
   end
   // ********************
   // State
   // ********************
   typedef struct packed {
      hsfw_tx_e   tx_st;
      logic [15:0] tx_cnt;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic       tx_o;
      hsfw_rx_e   rx_st;
      logic [15:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic       rx_s1;
      logic       rx_s2;
      logic       rx_v;
      logic [7:0] rx_d;
      logic       sp_act;
      logic [7:0] sp_div;
      logic [3:0] sp_edge;
      logic       sp_clk;
      logic [7:0] sp_sh;
      logic [7:0] sp_rx;
      hsfw_pwr_e  pwr;
      logic       wk;
      logic [`HSFW_GPIO_N-1:0] gp;
      logic [`HSFW_ADC_BITS-1:0] a0;
      logic [`HSFW_ADC_BITS-1:0] a1;
   } hsfw_top_s;
   hsfw_top_s s_q, s_d;
   logic rst_all;
   assign rst_all = sys_rst | ~hw_reset_n;
   // ********************
   // Next state
   // ********************
   always_comb begin
      s_d       = s_q;
      s_d.rx_s1 = serial_in;
      s_d.rx_s2 = s_q.rx_s1;
      s_d.wk    = 1'b0;
      // Serial transmit: holds start of a new byte while host not ready
      case (s_q.tx_st)
         HSFW_TX_IDLE: begin
            s_d.tx_o = 1'b1;
            if (tx_byte.valid && !host_ready_n) begin
               s_d.tx_sh  = tx_byte.data;
               s_d.tx_st  = HSFW_TX_START;
               s_d.tx_cnt = 16'(BIT_CYC - 1);
               s_d.tx_o   = 1'b0;
            end
         end
         HSFW_TX_START, HSFW_TX_DATA: begin
            if (s_q.tx_cnt == '0) begin
               s_d.tx_cnt = 16'(BIT_CYC - 1);
               s_d.tx_o   = s_q.tx_sh[0];
               s_d.tx_sh  = {1'b1, s_q.tx_sh[7:1]};
               if (s_q.tx_st == HSFW_TX_START) begin
                  s_d.tx_st  = HSFW_TX_DATA;
                  s_d.tx_bit = 3'h0;
               end else if (s_q.tx_bit == `HSFW_LAST_BIT) begin
                  s_d.tx_o  = 1'b1;
                  s_d.tx_st = HSFW_TX_STOP;
               end else begin
                  s_d.tx_o   = s_q.tx_sh[0];
                  s_d.tx_bit = s_q.tx_bit + 3'h1;
               end
            end else begin
               s_d.tx_cnt = s_q.tx_cnt - 16'h0001;
            end
         end
         HSFW_TX_STOP: begin
            if (s_q.tx_cnt == '0) s_d.tx_st = HSFW_TX_IDLE;
            else s_d.tx_cnt = s_q.tx_cnt - 16'h0001;
         end
         default: s_d.tx_st = HSFW_TX_IDLE;
      endcase
      // Serial receive, sampled mid-bit
      if (s_q.rx_v && rx_ready) s_d.rx_v = 1'b0;
      case (s_q.rx_st)
         HSFW_RX_IDLE: if (!s_q.rx_s2) begin
            s_d.rx_st  = HSFW_RX_START;
            s_d.rx_cnt = 16'(HALF - 1);
         end
         HSFW_RX_START: if (s_q.rx_cnt == '0) begin
            s_d.rx_cnt = 16'(BIT_CYC - 1);
            s_d.rx_bit = 3'h0;
            s_d.rx_st  = s_q.rx_s2 ? HSFW_RX_IDLE : HSFW_RX_DATA;
         end else s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
         HSFW_RX_DATA: if (s_q.rx_cnt == '0) begin
            s_d.rx_cnt = 16'(BIT_CYC - 1);
            s_d.rx_sh  = {s_q.rx_s2, s_q.rx_sh[7:1]};
            s_d.rx_bit = s_q.rx_bit + 3'h1;
            if (s_q.rx_bit == `HSFW_LAST_BIT) s_d.rx_st = HSFW_RX_STOP;
         end else s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
         HSFW_RX_STOP: if (s_q.rx_cnt == '0) begin
            s_d.rx_st = HSFW_RX_IDLE;
            // Bad stop bit drops the byte; a full holder not read in the same cycle keeps its byte and drops the new one
            if (s_q.rx_s2 && !s_d.rx_v) begin
               s_d.rx_v = 1'b1;
               s_d.rx_d = s_q.rx_sh;
            end
         end else s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
         default: s_d.rx_st = HSFW_RX_IDLE;
      endcase
      // SPI master: mode 0, divider sets half period
      if (!spi_master) begin
         s_d.sp_act = 1'b0;
         s_d.sp_clk = 1'b0;
      end else if (!s_q.sp_act) begin
         if (spi_start) begin
            s_d.sp_act  = 1'b1;
            s_d.sp_sh   = spi_tx_data;
            s_d.sp_div  = 8'(SPI_DV - 1);
            s_d.sp_edge = 4'h0;
         end
      end else if (s_q.sp_div != '0) begin
         s_d.sp_div = s_q.sp_div - 8'h01;
      end else begin
         s_d.sp_div  = 8'(SPI_DV - 1);
         s_d.sp_clk  = ~s_q.sp_clk;
         s_d.sp_edge = s_q.sp_edge + 4'h1;
         if (!s_q.sp_clk) s_d.sp_rx = {s_q.sp_rx[6:0], spi_in};
         else s_d.sp_sh = {s_q.sp_sh[6:0], 1'b0};
         if (s_q.sp_edge == `HSFW_SPI_LAST_EDGE) s_d.sp_act = 1'b0;
      end
      // Timer sleep and wake
      case (s_q.pwr)
         HSFW_AWAKE: if (sleep_req && !wake_in) s_d.pwr = HSFW_SLEEP;
         HSFW_SLEEP: if (wake_in) begin
            s_d.pwr = HSFW_AWAKE;
            s_d.wk  = 1'b1;
         end
         default: s_d.pwr = HSFW_AWAKE;
      endcase
      for (int i = 0; i < `HSFW_GPIO_N; i++) begin
         s_d.gp[i] = gp_dir_out[i] ? gp_wr[i] : gp_i[i];
      end
      // Converter codes, scaled to half when using supply reference
      s_d.a0 = adc_ref_sel ? analog_in_0 : {1'b0, analog_in_0[9:1]};
      s_d.a1 = adc_ref_sel ? analog_in_1 : {1'b0, analog_in_1[9:1]};
   end
   always_ff @(posedge core_clk or posedge rst_all) begin
      if (rst_all) begin
         s_q       <= '0;
         s_q.tx_st <= HSFW_TX_IDLE;
         s_q.tx_o  <= 1'b1;
         s_q.rx_st <= HSFW_RX_IDLE;
         s_q.rx_s1 <= 1'b1;
         s_q.rx_s2 <= 1'b1;
         s_q.pwr   <= HSFW_AWAKE;
      end else begin
         s_q <= s_d;
      end
   end
   // ********************
   // Outputs
   // ********************
   assign serial_out         = s_q.tx_o;
   assign tx_ready           = (s_q.tx_st == HSFW_TX_IDLE) && !host_ready_n;
   assign rx_byte            = '{valid: s_q.rx_v, data: s_q.rx_d};
   assign host_ready_to_rx_n = s_q.rx_v;
   assign spi_rx_data        = s_q.sp_rx;
   assign spi_busy           = s_q.sp_act;
   assign spi_out            = s_q.sp_sh[7];
   assign spi_sel_n = '{o: ~s_q.sp_act, oe_n: ~spi_master};
   assign spi_clk   = '{o: s_q.sp_clk, oe_n: ~spi_master};
   assign wake_out  = s_q.wk;
   assign asleep    = (s_q.pwr == HSFW_SLEEP);
   assign gp_o      = s_q.gp;
   assign gp_oe_n   = ~gp_dir_out;
   assign gp_pullup = ~gp_dir_out;
   assign gp_rd     = s_q.gp;
   assign adc_code_0 = s_q.a0;
   assign adc_code_1 = s_q.a1;
   hsfw_pwm #(.W(`HSFW_PWM_BITS)) hsfw_pwm_inst (
      .core_clk (core_clk),
      .sys_rst  (rst_all),
      .duty     (duty_set),
      .pwm_out  (duty_output_0),
      .filt_out (duty_filtered)
   );
   // ********************
   // Checks
   // ********************
   AST_RTR_FULL: assert property (@(posedge core_clk) disable iff (rst_all)
      rx_byte.valid |-> host_ready_to_rx_n) else $error("rtr low when full");
   AST_HOLD_TX: assert property (@(posedge core_clk) disable iff (rst_all)
      (s_q.tx_st == HSFW_TX_IDLE && host_ready_n) |=> s_q.tx_st == HSFW_TX_IDLE)
      else $error("tx began while host not ready");
   AST_WAKE: assert property (@(posedge core_clk) disable iff (rst_all)
      (asleep && wake_in) |=> (wake_out && !asleep)) else $error("no wake");
   AST_WAKE_OUT: assert property (@(posedge core_clk) disable iff (rst_all)
      wake_out |-> $past(asleep)) else $error("wake out w/o sleep");
   AST_SEL_DIR: assert property (@(posedge core_clk) disable iff (rst_all)
      !spi_master |-> spi_sel_n.oe_n) else $error("select driven as slave");
   AST_CLK_DIR: assert property (@(posedge core_clk) disable iff (rst_all)
      !spi_master |-> (spi_clk.oe_n && !spi_busy)) else $error("clk as slave");
   AST_SPI_LEN: assert property (@(posedge core_clk) disable iff (rst_all)
      (spi_start && spi_master && !spi_busy ##1 spi_master[*8]) |-> spi_busy)
      else $error("spi ended early");
   AST_PULLUP: assert property (@(posedge core_clk) disable iff (rst_all)
      gp_pullup == gp_oe_n) else $error("pull-up mismatch");
   AST_START_BIT: assert property (@(posedge core_clk) disable iff (rst_all)
      (s_q.tx_st == HSFW_TX_START) |-> !serial_out) else $error("start");
   AST_RESET_PIN: assert property (@(posedge core_clk)
      !hw_reset_n |=> (serial_out && !rx_byte.valid)) else $error("rst");
   CV_TX: cover property (@(posedge core_clk) s_q.tx_st == HSFW_TX_STOP);
   CV_RX: cover property (@(posedge core_clk) $rose(rx_byte.valid));
   CV_SPI: cover property (@(posedge core_clk) $fell(spi_busy));
   CV_WAKE: cover property (@(posedge core_clk) wake_out);
endmodule

// ---- hsfw_host_model.sv ----
// Host side model: serial transmitter and receiver on the data port
`timescale 1ns/100ps
module hsfw_host_model #(
   parameter int BIT_CYC = 4
) (
   // Clock
   input  wire logic core_clk,
   // Serial lines
   input  wire logic line_in,
   output logic      line_out,
   // Flow control from the module
   input  wire logic rtr_n
);
   logic [7:0] got_q = 8'h00;
   int         got_n = 0;
   initial line_out = 1'b1;

   // Idle line stays high between frames, as a pulled-up line would
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      while (rtr_n !== 1'b0) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk);
         line_out <= fr[i];
         repeat (BIT_CYC - 1) @(posedge core_clk);
      end
   endtask

   // Sampling on the falling edge keeps clear of the module's updates
   always begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(negedge core_clk);
      if (line_in === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(negedge core_clk);
            got_q[i] = line_in;
         end
         repeat (BIT_CYC) @(negedge core_clk);
         if (line_in === 1'b1) got_n++;
      end
   end
endmodule

// ---- hsfw_top_test.sv ----
// Self-checking bench for the host serial, flow and wake block
`timescale 1ns/100ps
module hsfw_top_test;
   import hsfw_pkg::*;
   logic core_clk = 0, sys_rst = 1, hw_reset_n = 0, serial_in, serial_out;
   logic rtr_n, host_ready_n = 1, tx_ready, rx_ready = 0, spi_master = 0;
   logic spi_start = 0, spi_busy, spi_in = 0, spi_out, sel_i = 1, sclk_i = 0;
   logic sleep_req = 0, wake_in = 0, wake_out, asleep, adc_ref = 1, pwm;
   logic [7:0] spi_tx = 8'h00, spi_rx;
   hsfw_byte_s tx_b = '0, rx_b;
   hsfw_pin_s sel, sclk;
   logic [3:0] gdir = 4'h0, gwr = 4'h0, gi = 4'h0, go, goe, gpu, grd;
   logic [15:0] duty = 16'h0000, filt;
   logic [9:0] a0 = 10'h000, a1 = 10'h000, c0, c1;
   int failures = 0, comparisons = 0, cyc = 0, wake_cnt = 0, busy_cnt = 0;

   hsfw_top #(.BAUD(2500000)) hsfw_top_inst (
      .core_clk, .sys_rst, .hw_reset_n, .serial_in, .serial_out,
      .host_ready_to_rx_n(rtr_n), .host_ready_n, .tx_byte(tx_b), .tx_ready,
      .rx_byte(rx_b), .rx_ready, .spi_master, .spi_start,
      .spi_tx_data(spi_tx), .spi_rx_data(spi_rx), .spi_busy, .spi_in,
      .spi_out, .spi_sel_n_i(sel_i), .spi_sel_n(sel), .spi_clk_i(sclk_i),
      .spi_clk(sclk), .sleep_req, .wake_in, .wake_out, .asleep,
      .gp_dir_out(gdir), .gp_wr(gwr), .gp_i(gi), .gp_o(go), .gp_oe_n(goe),
      .gp_pullup(gpu), .gp_rd(grd), .duty_set(duty), .duty_output_0(pwm),
      .duty_filtered(filt), .analog_in_0(a0), .analog_in_1(a1),
      .adc_ref_sel(adc_ref), .adc_code_0(c0), .adc_code_1(c1));

   hsfw_host_model #(.BIT_CYC(4)) hsfw_host_model_inst (
      .core_clk, .line_in(serial_out), .line_out(serial_in), .rtr_n(rtr_n));

   always #50 core_clk = ~core_clk;

   // Echoing slave, and released select and clock pins pulled to idle
   always @(posedge core_clk) begin
      spi_in <= spi_out;
      sel_i <= sel.oe_n | sel.o;
      sclk_i <= sclk.oe_n ? 1'b0 : sclk.o;
   end

   always @(negedge core_clk) begin
      wake_cnt += int'(wake_out === 1'b1);
      busy_cnt += int'(spi_busy === 1'b1);
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end

   task automatic chk(input string n, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic t_tx;
      int n;
      n = hsfw_host_model_inst.got_n;
      @(posedge core_clk);
      host_ready_n <= 1;
      tx_b <= '{1'b1, 8'hA5};
      idle(6);
      chk("tx_ready", 0, tx_ready);
      chk("serial_out", 1, serial_out);
      @(posedge core_clk);
      host_ready_n <= 0;
      for (int i = 0; i < 8 && tx_ready !== 1'b1; i++) idle(1);
      @(posedge core_clk);
      tx_b.valid <= 0;
      for (int i = 0; i < 100 && hsfw_host_model_inst.got_n == n; i++)
         idle(1);
      chk("tx_data", 8'hA5, hsfw_host_model_inst.got_q);
      $display("test tx done");
   endtask

   task automatic t_rx;
      hsfw_host_model_inst.send_byte(8'h3C);
      for (int i = 0; i < 60 && rx_b.valid !== 1'b1; i++) idle(1);
      chk("rx_data", 8'h3C, rx_b.data);
      chk("rtr_n_full", 1, rtr_n);
      idle(3);
      chk("rx_held", 1, rx_b.valid);
      @(posedge core_clk);
      rx_ready <= 1;
      @(posedge core_clk);
      rx_ready <= 0;
      idle(2);
      chk("rtr_n_free", 0, rtr_n);
      $display("test rx done");
   endtask

   // Reset pin pulled low in mid-frame must abort everything
   task automatic t_reset;
      @(posedge core_clk);
      tx_b <= '{1'b1, 8'h00};
      @(posedge core_clk);
      tx_b.valid <= 0;
      idle(8);
      @(posedge core_clk);
      hw_reset_n <= 0;
      idle(2);
      chk("rst_serial_out", 1, serial_out);
      chk("rst_rtr_n", 0, rtr_n);
      chk("rst_busy", 0, spi_busy);
      chk("rst_wake_out", 0, wake_out);
      @(posedge core_clk);
      hw_reset_n <= 1;
      idle(60);
      $display("test reset done");
   endtask

   task automatic t_wake;
      wake_cnt = 0;
      @(posedge core_clk);
      wake_in <= 1;
      @(posedge core_clk);
      wake_in <= 0;
      idle(5);
      chk("awake_pulses", 0, 16'(wake_cnt));
      @(posedge core_clk);
      sleep_req <= 1;
      @(posedge core_clk);
      sleep_req <= 0;
      idle(2);
      chk("asleep", 1, asleep);
      wake_cnt = 0;
      @(posedge core_clk);
      wake_in <= 1;
      @(posedge core_clk);
      wake_in <= 0;
      idle(5);
      chk("wake_pulses", 1, 16'(wake_cnt));
      chk("woken", 0, asleep);
      $display("test wake done");
   endtask

   task automatic t_spi;
      @(posedge core_clk);
      spi_start <= 1;
      @(posedge core_clk);
      spi_start <= 0;
      idle(2);
      chk("slave_sel_oe_n", 1, sel.oe_n);
      chk("slave_clk_oe_n", 1, sclk.oe_n);
      chk("slave_busy", 0, spi_busy);
      @(posedge core_clk);
      spi_master <= 1;
      spi_tx <= 8'h96;
      idle(2);
      chk("master_sel_oe_n", 0, sel.oe_n);
      chk("master_clk_oe_n", 0, sclk.oe_n);
      busy_cnt = 0;
      @(posedge core_clk);
      spi_start <= 1;
      @(posedge core_clk);
      spi_start <= 0;
      idle(2);
      chk("sel_active", 0, sel.o);
      for (int i = 0; i < 100 && spi_busy === 1'b1; i++) idle(1);
      chk("busy_cycles", 64, 16'(busy_cnt));
      chk("spi_rx", 8'h96, spi_rx);
      chk("clk_idle", 0, sclk.o);
      $display("test spi done");
   endtask

   task automatic t_misc;
      @(posedge core_clk);
      gdir <= 4'hA;
      gwr <= 4'hF;
      gi <= 4'h6;
      a0 <= 10'h2F1;
      a1 <= 10'h155;
      idle(3);
      chk("gp_pullup", 4'h5, gpu);
      chk("gp_oe_n", 4'h5, goe);
      // Readback shows the driven level on output pins, the pin on inputs
      chk("gp_rd", 4'hE, grd);
      chk("gp_o_driven", 4'hA, go & gdir);
      chk("duty_zero", 0, pwm);
      chk("duty_filt_zero", 0, filt);
      chk("analog_in_0_full", 10'h2F1, c0);
      chk("analog_in_1_full", 10'h155, c1);
      @(posedge core_clk);
      adc_ref <= 0;
      idle(3);
      chk("analog_in_0_half", 10'h178, c0);
      chk("analog_in_1_half", 10'h0AA, c1);
      // Full duty: filter settles to full scale well inside 300 cycles
      @(posedge core_clk);
      duty <= 16'hFFFF;
      idle(300);
      chk("duty_full", 1, pwm);
      chk("duty_filt_full", 16'hFFFF, filt);
      $display("test misc done");
   endtask

   initial begin
      repeat (12) @(posedge core_clk);
      sys_rst <= 0;
      hw_reset_n <= 1;
      idle(2);
      t_tx();
      t_rx();
      t_reset();
      t_wake();
      t_spi();
      t_misc();
      results();
   end
endmodule
